// File: inc/hlef_flag_if.sv
`timescale 1ns/1ps
`default_nettype none
// Carries one controller's flags between the register file and its flag logic.
interface hlef_flag_if;
   logic [7:0] status;
   logic [6:0] enable;
   logic       rd_clr;
   logic       hit;
   modport core (input enable, input rd_clr, output status, output hit);
   modport regs (output enable, output rd_clr, input status, input hit);
endinterface // hlef_flag_if
`default_nettype wire

// File: inc/hlef_pkg.sv
// How it works
// - Enable bit 2 gates the check error interrupt; it resets to 0.
// - Enable bit 1 gates the abort interrupt; abort is seven consecutive ones.
// - Enable bit 0 gates the idle interrupt; idle is the octet 0x7E.
// - Status bit 7 shows the last message kind; software cannot change it.
// - Event status bits reset to 0, latch on events, clear after a read.
// - Status bit 6 is set when sending of a message begins.
// - Status bit 5 is set when receiving of a message begins.
// - Status bit 4 is set when sending of a message completes.
// - Status bit 3 is set when a message arrived or the buffer filled.
package hlef_pkg;

   // Number of link controllers served: index 0 is link 2, index 1 is link 3.
   localparam int unsigned HLEF_NUM_CTL = 2;

   // Register indices as printed; the byte address is four times the index.
   localparam logic [15:0] HLEF_IDX_L2_STATUS = 16'h0B16;
   localparam logic [15:0] HLEF_IDX_L2_ENABLE = 16'h0B17;
   localparam logic [15:0] HLEF_IDX_L3_STATUS = 16'h0B26;
   localparam logic [15:0] HLEF_IDX_L3_ENABLE = 16'h0B27;
   localparam logic [15:0] HLEF_ADDR_L2_STATUS = {HLEF_IDX_L2_STATUS[13:0], 2'b00};
   localparam logic [15:0] HLEF_ADDR_L2_ENABLE = {HLEF_IDX_L2_ENABLE[13:0], 2'b00};
   localparam logic [15:0] HLEF_ADDR_L3_STATUS = {HLEF_IDX_L3_STATUS[13:0], 2'b00};
   localparam logic [15:0] HLEF_ADDR_L3_ENABLE = {HLEF_IDX_L3_ENABLE[13:0], 2'b00};

   // Bit positions of the status register; the enable register shares bits 0 to 6.
   localparam int unsigned HLEF_BIT_IDLE    = 0;
   localparam int unsigned HLEF_BIT_ABORT   = 1;
   localparam int unsigned HLEF_BIT_CHECK   = 2;
   localparam int unsigned HLEF_BIT_RX_DONE = 3;
   localparam int unsigned HLEF_BIT_TX_DONE = 4;
   localparam int unsigned HLEF_BIT_RX_BEG  = 5;
   localparam int unsigned HLEF_BIT_TX_BEG  = 6;
   localparam int unsigned HLEF_BIT_KIND    = 7;

   // Reset values of the registers and of the line watch.
   localparam logic [6:0] HLEF_EVT_RST    = 7'h00;
   localparam logic [6:0] HLEF_ENABLE_RST = 7'h00;
   localparam logic       HLEF_KIND_RST   = 1'b0;
   localparam logic [7:0] HLEF_SHIFT_RST  = 8'h00;
   localparam logic [2:0] HLEF_ONES_RST   = 3'h0;

   // Line patterns: the flag octet and the run of ones that marks an abort.
   localparam logic [7:0] HLEF_FLAG_OCTET = 8'h7E;
   localparam logic [2:0] HLEF_ABORT_RUN  = 3'h7;

   // AXI4-Lite response codes.
   localparam logic [1:0] HLEF_RESP_OKAY   = 2'h0;
   localparam logic [1:0] HLEF_RESP_SLVERR = 2'h2;

   // Register selector produced by the address decoder.
   typedef enum logic [2:0] {
      HLEF_SEL_NONE   = 3'h0,
      HLEF_SEL_STATUS = 3'h1,
      HLEF_SEL_ENABLE = 3'h2
   } hlef_sel_t;

endpackage

// File: src/hlef_event_flags.sv
`timescale 1ns/1ps
`default_nettype none
module hlef_event_flags
   import hlef_pkg::*;
(
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic line_valid,
   input  wire logic line_bit,
   input  wire logic check_error,
   input  wire logic receive_begin,
   input  wire logic receive_done,
   input  wire logic send_begin,
   input  wire logic send_done,
   input  wire logic kind_valid,
   input  wire logic kind_mos,
   hlef_flag_if.core fl
);

   logic [7:0] shift_q;
   logic [7:0] shift_d;
   logic [2:0] ones_q;
   logic [2:0] ones_d;
   logic [6:0] evt_q;
   logic [6:0] evt_d;
   logic       kind_q;
   logic       kind_d;
   logic [7:0] shift_new;
   logic       flag_seen;
   logic       abort_seen;
   logic [6:0] set;

   // Line watch, event latching and message kind capture.
   always_comb begin
      shift_new  = {shift_q[6:0], line_bit};
      shift_d    = line_valid ? shift_new : shift_q;
      flag_seen  = line_valid && (shift_new == HLEF_FLAG_OCTET);
      abort_seen = line_valid && line_bit && (ones_q == HLEF_ABORT_RUN - 3'h1);
      ones_d     = ones_q;
      if (line_valid) begin
         if (!line_bit) begin
            ones_d = HLEF_ONES_RST;
         end else if (ones_q != HLEF_ABORT_RUN) begin
            ones_d = ones_q + 3'h1;
         end
      end
      set                  = HLEF_EVT_RST;
      set[HLEF_BIT_IDLE]   = flag_seen;
      set[HLEF_BIT_ABORT]  = abort_seen;
      set[HLEF_BIT_CHECK]  = check_error;
      set[HLEF_BIT_RX_DONE] = receive_done;
      set[HLEF_BIT_TX_DONE] = send_done;
      set[HLEF_BIT_RX_BEG] = receive_begin;
      set[HLEF_BIT_TX_BEG] = send_begin;
      // A set in the clearing cycle survives the clear.
      evt_d  = (fl.rd_clr ? HLEF_EVT_RST : evt_q) | set;
      kind_d = kind_valid ? kind_mos : kind_q;
   end

   // State registers.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         shift_q <= HLEF_SHIFT_RST;
         ones_q  <= HLEF_ONES_RST;
         evt_q   <= HLEF_EVT_RST;
         kind_q  <= HLEF_KIND_RST;
      end else begin
         shift_q <= shift_d;
         ones_q  <= ones_d;
         evt_q   <= evt_d;
         kind_q  <= kind_d;
      end
   end

   // The kind bit never raises an interrupt; only event bits are gated.
   assign fl.status = {kind_q, evt_q};
   assign fl.hit    = |(evt_q & fl.enable);

endmodule // hlef_event_flags
`default_nettype wire

// File: src/hlef_top.sv
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module hlef_top
   import hlef_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write address channel.
   input  wire logic [15:0] s_axi_awaddr,
   input  wire logic [2:0]  s_axi_awprot,
   input  wire logic        s_axi_awvalid,
   output var  logic        s_axi_awready,
   // AXI4-Lite write data channel.
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output var  logic        s_axi_wready,
   // AXI4-Lite write response channel.
   output var  logic [1:0]  s_axi_bresp,
   output var  logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read address channel.
   input  wire logic [15:0] s_axi_araddr,
   input  wire logic [2:0]  s_axi_arprot,
   input  wire logic        s_axi_arvalid,
   output var  logic        s_axi_arready,
   // AXI4-Lite read data channel.
   output var  logic [31:0] s_axi_rdata,
   output var  logic [1:0]  s_axi_rresp,
   output var  logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Per controller event inputs; bit 0 is link 2, bit 1 is link 3.
   input  wire logic [1:0]  line_valid,
   input  wire logic [1:0]  line_bit,
   input  wire logic [1:0]  check_error,
   input  wire logic [1:0]  receive_begin,
   input  wire logic [1:0]  receive_done,
   input  wire logic [1:0]  send_begin,
   input  wire logic [1:0]  send_done,
   input  wire logic [1:0]  kind_valid,
   input  wire logic [1:0]  kind_mos,
   // Level interrupt to the host.
   output var  logic        irq
);

   // Read channel states.
   typedef enum logic [1:0] {
      HLEF_RD_IDLE = 2'b01,
      HLEF_RD_RESP = 2'b10
   } hlef_rd_state_t;

   // Write channel states.
   typedef enum logic [2:0] {
      HLEF_WR_COLLECT = 3'b001,
      HLEF_WR_APPLY   = 3'b010,
      HLEF_WR_RESP    = 3'b100
   } hlef_wr_state_t;

   hlef_rd_state_t rd_state_q;
   hlef_rd_state_t rd_state_d;
   hlef_wr_state_t wr_state_q;
   hlef_wr_state_t wr_state_d;

   logic [15:0] aw_addr_q;
   logic [15:0] aw_addr_d;
   logic        aw_have_q;
   logic        aw_have_d;
   logic [31:0] w_data_q;
   logic [31:0] w_data_d;
   logic [3:0]  w_strb_q;
   logic [3:0]  w_strb_d;
   logic        w_have_q;
   logic        w_have_d;
   logic        awready_q;
   logic        awready_d;
   logic        wready_q;
   logic        wready_d;
   logic        bvalid_q;
   logic        bvalid_d;
   logic [1:0]  bresp_q;
   logic [1:0]  bresp_d;
   logic        arready_q;
   logic        arready_d;
   logic        rvalid_q;
   logic        rvalid_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic [1:0]  rresp_q;
   logic [1:0]  rresp_d;
   logic        irq_q;
   logic        irq_d;

   logic [6:0]  enable_q [HLEF_NUM_CTL];
   logic [6:0]  enable_d [HLEF_NUM_CTL];
   logic [7:0]  status   [HLEF_NUM_CTL];
   logic [1:0]  hit;
   logic [1:0]  rd_clr;

   logic        aw_fire;
   logic        w_fire;
   logic        ar_fire;
   hlef_sel_t   wr_sel;
   hlef_sel_t   rd_sel;
   logic        wr_ctl;
   logic        rd_ctl;

   // Maps a byte address to a register kind and the controller it belongs to.
   function automatic hlef_sel_t hlef_decode(input logic [15:0] addr, output logic ctl);
      hlef_sel_t sel;
      sel = HLEF_SEL_NONE;
      ctl = 1'b0;
      case (addr)
         HLEF_ADDR_L2_STATUS: begin
            sel = HLEF_SEL_STATUS;
         end
         HLEF_ADDR_L2_ENABLE: begin
            sel = HLEF_SEL_ENABLE;
         end
         HLEF_ADDR_L3_STATUS: begin
            sel = HLEF_SEL_STATUS;
            ctl = 1'b1;
         end
         HLEF_ADDR_L3_ENABLE: begin
            sel = HLEF_SEL_ENABLE;
            ctl = 1'b1;
         end
         default: begin
            sel = HLEF_SEL_NONE;
         end
      endcase
      return sel;
   endfunction

   // One flag block per controller, joined through its own interface.
   for (genvar i = 0; i < HLEF_NUM_CTL; i++) begin : gen_ctl
      hlef_flag_if u_fl ();

      assign u_fl.enable = enable_q[i];
      assign u_fl.rd_clr = rd_clr[i];
      assign status[i]   = u_fl.status;
      assign hit[i]      = u_fl.hit;

      hlef_event_flags u_flags (
         .aclk          (aclk),
         .aresetn       (aresetn),
         .line_valid    (line_valid[i]),
         .line_bit      (line_bit[i]),
         .check_error   (check_error[i]),
         .receive_begin (receive_begin[i]),
         .receive_done  (receive_done[i]),
         .send_begin    (send_begin[i]),
         .send_done     (send_done[i]),
         .kind_valid    (kind_valid[i]),
         .kind_mos      (kind_mos[i]),
         .fl            (u_fl.core)
      );
   end

   // Handshakes and address decode of both channels.
   always_comb begin
      aw_fire = s_axi_awvalid && awready_q;
      w_fire  = s_axi_wvalid && wready_q;
      ar_fire = s_axi_arvalid && arready_q;
      wr_sel  = hlef_decode(aw_addr_q, wr_ctl);
      rd_sel  = hlef_decode(s_axi_araddr, rd_ctl);
   end

   // Write side: address and data arrive in either order, then one response.
   always_comb begin
      wr_state_d = wr_state_q;
      aw_addr_d  = aw_addr_q;
      aw_have_d  = aw_have_q;
      w_data_d   = w_data_q;
      w_strb_d   = w_strb_q;
      w_have_d   = w_have_q;
      bvalid_d   = bvalid_q;
      bresp_d    = bresp_q;
      enable_d   = enable_q;
      case (wr_state_q)
         HLEF_WR_COLLECT: begin
            if (aw_fire) begin
               aw_addr_d = s_axi_awaddr;
               aw_have_d = 1'b1;
            end
            if (w_fire) begin
               w_data_d = s_axi_wdata;
               w_strb_d = s_axi_wstrb;
               w_have_d = 1'b1;
            end
            if (aw_have_d && w_have_d) begin
               wr_state_d = HLEF_WR_APPLY;
            end
         end
         HLEF_WR_APPLY: begin
            // Only the enable registers take data; status writes are ignored.
            bresp_d = HLEF_RESP_OKAY;
            if (wr_sel == HLEF_SEL_NONE) begin
               bresp_d = HLEF_RESP_SLVERR;
            end else if (wr_sel == HLEF_SEL_ENABLE && w_strb_q[0]) begin
               enable_d[wr_ctl] = w_data_q[6:0];
            end
            aw_have_d  = 1'b0;
            w_have_d   = 1'b0;
            bvalid_d   = 1'b1;
            wr_state_d = HLEF_WR_RESP;
         end
         HLEF_WR_RESP: begin
            if (s_axi_bready) begin
               bvalid_d   = 1'b0;
               wr_state_d = HLEF_WR_COLLECT;
            end
         end
         default: begin
            wr_state_d = HLEF_WR_COLLECT;
            aw_have_d  = 1'b0;
            w_have_d   = 1'b0;
            bvalid_d   = 1'b0;
         end
      endcase
      awready_d = (wr_state_d == HLEF_WR_COLLECT) && !aw_have_d;
      wready_d  = (wr_state_d == HLEF_WR_COLLECT) && !w_have_d;
   end

   // Write side registers.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state_q <= HLEF_WR_COLLECT;
         aw_addr_q  <= 16'h0000;
         aw_have_q  <= 1'b0;
         w_data_q   <= 32'h00000000;
         w_strb_q   <= 4'h0;
         w_have_q   <= 1'b0;
         awready_q  <= 1'b0;
         wready_q   <= 1'b0;
         bvalid_q   <= 1'b0;
         bresp_q    <= HLEF_RESP_OKAY;
         enable_q   <= '{default: HLEF_ENABLE_RST};
      end else begin
         wr_state_q <= wr_state_d;
         aw_addr_q  <= aw_addr_d;
         aw_have_q  <= aw_have_d;
         w_data_q   <= w_data_d;
         w_strb_q   <= w_strb_d;
         w_have_q   <= w_have_d;
         awready_q  <= awready_d;
         wready_q   <= wready_d;
         bvalid_q   <= bvalid_d;
         bresp_q    <= bresp_d;
         enable_q   <= enable_d;
      end
   end

   // Read side: capture data on the address handshake and clear read flags.
   always_comb begin
      rd_state_d = rd_state_q;
      rvalid_d   = rvalid_q;
      rdata_d    = rdata_q;
      rresp_d    = rresp_q;
      rd_clr     = 2'b00;
      case (rd_state_q)
         HLEF_RD_IDLE: begin
            if (ar_fire) begin
               rdata_d = 32'h00000000;
               rresp_d = HLEF_RESP_OKAY;
               case (rd_sel)
                  HLEF_SEL_STATUS: begin
                     rdata_d[7:0]   = status[rd_ctl];
                     rd_clr[rd_ctl] = 1'b1;
                  end
                  HLEF_SEL_ENABLE: begin
                     rdata_d[6:0] = enable_q[rd_ctl];
                  end
                  default: begin
                     rresp_d = HLEF_RESP_SLVERR;
                  end
               endcase
               rvalid_d   = 1'b1;
               rd_state_d = HLEF_RD_RESP;
            end
         end
         HLEF_RD_RESP: begin
            if (s_axi_rready) begin
               rvalid_d   = 1'b0;
               rd_state_d = HLEF_RD_IDLE;
            end
         end
         default: begin
            rvalid_d   = 1'b0;
            rd_state_d = HLEF_RD_IDLE;
         end
      endcase
      arready_d = (rd_state_d == HLEF_RD_IDLE);
   end

   // Read side registers.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state_q <= HLEF_RD_IDLE;
         arready_q  <= 1'b0;
         rvalid_q   <= 1'b0;
         rdata_q    <= 32'h00000000;
         rresp_q    <= HLEF_RESP_OKAY;
      end else begin
         rd_state_q <= rd_state_d;
         arready_q  <= arready_d;
         rvalid_q   <= rvalid_d;
         rdata_q    <= rdata_d;
         rresp_q    <= rresp_d;
      end
   end

   // The interrupt follows any enabled latched event, one cycle later.
   always_comb begin
      irq_d = |hit;
   end

   // Interrupt register.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= irq_d;
      end
   end

   // All outputs come straight from registers.
   assign s_axi_awready = awready_q;
   assign s_axi_wready  = wready_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;
   assign irq           = irq_q;

endmodule // hlef_top
`default_nettype wire

// File: test/hdlc_link_event_flags_test.sv
`timescale 1ns/1ps
`default_nettype none
module hdlc_link_event_flags_test
   import hlef_pkg::*;
();
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [15:0] s_axi_awaddr, s_axi_araddr;
   logic [2:0]  s_axi_awprot, s_axi_arprot;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, kind_valid, kind_mos;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, irq;
   logic        lnk, src_slow, src_start, src_busy, src_v, src_b;
   logic [7:0]  src_octet;
   logic [1:0]  ev [2:6];
   int          checked = 0;
   int          num_errors = 0;
   // Event pulses and the line from the remote source, steered to one link.
   wire  [1:0]  check_error = ev[2];
   wire  [1:0]  receive_done = ev[3];
   wire  [1:0]  send_done = ev[4];
   wire  [1:0]  receive_begin = ev[5];
   wire  [1:0]  send_begin = ev[6];
   wire  [1:0]  line_valid = lnk ? {src_v, 1'b0} : {1'b0, src_v};
   wire  [1:0]  line_bit = {2{src_b}};

   hlef_top dut (.*);
   hlef_link_source src (.aclk, .slow(src_slow), .start(src_start),
      .octet(src_octet), .busy(src_busy), .valid(src_v), .data(src_b));

   // Free running bench clock.
   initial forever #25 aclk = ~aclk;

   // Expected register images.
   function automatic logic [31:0] ev_bit(input int k);
      return 32'h1 << k;
   endfunction
   function automatic logic [31:0] en_read(input logic [31:0] w);
      return w & 32'h7F;
   endfunction

   // Compares of data words and of single flags.
   task automatic chk_word(input logic [31:0] e, input logic [31:0] a);
      checked++;
      if (a !== e) begin
         num_errors++;
         $display("Error at %0t: expected %h got %h", $time, e, a);
      end
   endtask
   task automatic chk_flag(input logic e, input logic a);
      chk_word({31'h0, e}, {31'h0, a});
   endtask

   // Bus write; ready to take the answer may come late at random.
   task automatic wc(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] e);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awprot <= 3'($urandom);
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'($urandom);
      for (int i = 0; i < 60; i++) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) begin
            chk_word({30'h0, e}, {30'h0, s_axi_bresp});
            s_axi_bready <= 1'b0;
            break;
         end
         s_axi_bready <= 1'b1;
      end
   endtask

   // Bus read, same handshake discipline as the write.
   task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arprot <= 3'($urandom);
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'($urandom);
      for (int i = 0; i < 60; i++) begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            break;
         end
         s_axi_rready <= 1'b1;
      end
   endtask
   task automatic rc(input logic [15:0] a, input logic [31:0] e, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0]  r;
      rd(a, d, r);
      chk_word(e, d);
      chk_word({30'h0, er}, {30'h0, r});
   endtask

   // One cycle event pulse, a message kind report, and one octet on a line.
   task automatic pulse(input int l, input int k);
      @(posedge aclk);
      ev[k][l] <= 1'b1;
      @(posedge aclk);
      ev[k][l] <= 1'b0;
   endtask
   task automatic kind(input logic m);
      @(posedge aclk);
      kind_valid[1] <= 1'b1;
      kind_mos[1] <= m;
      @(posedge aclk);
      kind_valid[1] <= 1'b0;
   endtask
   task automatic send(input logic l, input logic [7:0] o);
      @(posedge aclk);
      lnk <= l;
      src_octet <= o;
      src_slow <= 1'($urandom);
      src_start <= 1'b1;
      @(posedge aclk);
      src_start <= 1'b0;
      // Busy rises only after this edge, so wait an edge before looking.
      for (int i = 0; i < 40; i++) begin
         @(posedge aclk);
         if (!src_busy) break;
      end
      repeat (3) @(posedge aclk);
   endtask

   task automatic tdone(input string n);
      $display("%0t: test %s done", $time, n);
   endtask
   task automatic complete_run();
      $display("comparisons %0d, mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // Cuts a hung run short far beyond the few hundred cycles of the tests.
   initial begin
      repeat (20000) @(posedge aclk);
      num_errors++;
      complete_run();
   end

   // Main sequence of tests.
   initial begin
      logic [15:0] st, en;
      logic [31:0] d;
      logic [1:0]  r;
      void'($urandom(32'h0616FC48));
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, s_axi_awprot} = '0;
      {s_axi_arprot, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
      {s_axi_rready, kind_valid, kind_mos, lnk, src_start, src_slow, src_octet} = '0;
      foreach (ev[i]) ev[i] = 2'b00;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      chk_flag(1'b0, irq);
      rc(HLEF_ADDR_L2_ENABLE, 32'h0, HLEF_RESP_OKAY);
      rc(HLEF_ADDR_L2_STATUS, 32'h0, HLEF_RESP_OKAY);
      rc(HLEF_ADDR_L3_ENABLE, 32'h0, HLEF_RESP_OKAY);
      wc(HLEF_ADDR_L3_STATUS, 32'hFF, 4'hF, HLEF_RESP_OKAY);
      rc(HLEF_ADDR_L3_STATUS, 32'h0, HLEF_RESP_OKAY);
      tdone("reset");
      repeat (4) begin
         d = $urandom;
         wc(HLEF_ADDR_L2_ENABLE, d, 4'hF, HLEF_RESP_OKAY);
         rc(HLEF_ADDR_L2_ENABLE, en_read(d), HLEF_RESP_OKAY);
         wc(HLEF_ADDR_L3_ENABLE, ~d, 4'hF, HLEF_RESP_OKAY);
         rc(HLEF_ADDR_L3_ENABLE, en_read(~d), HLEF_RESP_OKAY);
      end
      wc(HLEF_ADDR_L2_ENABLE, ~d, {3'($urandom), 1'b0}, HLEF_RESP_OKAY);
      rc(HLEF_ADDR_L2_ENABLE, en_read(d), HLEF_RESP_OKAY);
      wc(16'h0004, d, 4'hF, HLEF_RESP_SLVERR);
      rc(16'h0004, 32'h0, HLEF_RESP_SLVERR);
      tdone("registers");
      for (int l = 0; l < 2; l++) begin
         st = l ? HLEF_ADDR_L3_STATUS : HLEF_ADDR_L2_STATUS;
         en = l ? HLEF_ADDR_L3_ENABLE : HLEF_ADDR_L2_ENABLE;
         wc(l ? HLEF_ADDR_L2_ENABLE : HLEF_ADDR_L3_ENABLE, 32'h0, 4'hF, HLEF_RESP_OKAY);
         for (int k = 2; k < 7; k++) begin
            wc(en, ev_bit(k), 4'hF, HLEF_RESP_OKAY);
            pulse(l, k);
            repeat (3) @(posedge aclk);
            chk_flag(1'b1, irq);
            rc(st, ev_bit(k), HLEF_RESP_OKAY);
            repeat (2) @(posedge aclk);
            chk_flag(1'b0, irq);
            wc(en, 32'($urandom) & 32'h7F & ~ev_bit(k), 4'hF, HLEF_RESP_OKAY);
            pulse(l, k);
            repeat (3) @(posedge aclk);
            chk_flag(1'b0, irq);
            rc(st, ev_bit(k), HLEF_RESP_OKAY);
         end
      end
      tdone("events");
      send(1'b0, 8'h7E);
      rc(HLEF_ADDR_L2_STATUS, ev_bit(HLEF_BIT_IDLE), HLEF_RESP_OKAY);
      send(1'b0, 8'hFF);
      rc(HLEF_ADDR_L2_STATUS, ev_bit(HLEF_BIT_ABORT), HLEF_RESP_OKAY);
      send(1'b1, 8'h7E);
      rc(HLEF_ADDR_L3_STATUS, ev_bit(HLEF_BIT_IDLE), HLEF_RESP_OKAY);
      tdone("line");
      kind(1'b1);
      rc(HLEF_ADDR_L3_STATUS, 32'h80, HLEF_RESP_OKAY);
      wc(HLEF_ADDR_L3_STATUS, 32'h0, 4'hF, HLEF_RESP_OKAY);
      rc(HLEF_ADDR_L3_STATUS, 32'h80, HLEF_RESP_OKAY);
      kind(1'b0);
      rc(HLEF_ADDR_L3_STATUS, 32'h0, HLEF_RESP_OKAY);
      tdone("kind");
      repeat (2) @(posedge aclk);
      fork
         rd(HLEF_ADDR_L3_STATUS, d, r);
         pulse(1, 6);
      join
      chk_word(32'h0, d);
      rc(HLEF_ADDR_L3_STATUS, ev_bit(6), HLEF_RESP_OKAY);
      // The host has refilled on send begin; the send then completes.
      pulse(1, 4);
      rc(HLEF_ADDR_L3_STATUS, ev_bit(4), HLEF_RESP_OKAY);
      tdone("read race");
      complete_run();
   end
endmodule // hdlc_link_event_flags_test
`default_nettype wire

// File: test/hlef_link_source.sv
`timescale 1ns/1ps
`default_nettype none
// Remote line source: shifts one octet out, most significant bit first.
module hlef_link_source (
   input  wire logic       aclk,
   input  wire logic       slow,
   input  wire logic       start,
   input  wire logic [7:0] octet,
   output logic            busy,
   output logic            valid,
   output logic            data
);
   logic [7:0] sr_q = 8'h00;
   logic [3:0] cnt_q = 4'h0;
   logic       ph_q = 1'b0;
   // Known line levels before the first octet.
   initial begin
      valid = 1'b0;
      data = 1'b0;
   end
   // One strobe per bit; a slow source leaves a gap cycle between bits.
   // Off the strobe the line flips, so no stale bit can pass for data.
   always @(posedge aclk) begin
      valid <= 1'b0;
      data <= ~data;
      ph_q <= slow ? ~ph_q : 1'b1;
      if (start && cnt_q == 4'h0) begin
         sr_q <= octet;
         cnt_q <= 4'h8;
      end else if (cnt_q != 4'h0 && ph_q) begin
         valid <= 1'b1;
         data <= sr_q[7];
         sr_q <= {sr_q[6:0], 1'b0};
         cnt_q <= cnt_q - 4'h1;
      end
   end
   assign busy = cnt_q != 4'h0;
endmodule // hlef_link_source
`default_nettype wire

// File: test/hlef_properties.sv
`timescale 1ns/1ps
`default_nettype none
// Bus protocol checks on the ports of hlef_top.
module hlef_properties
   import hlef_pkg::*;
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [15:0] s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [15:0] s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Taking steps of the read and write channels.
   sequence rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // True for the four register addresses.
   function automatic logic mapped(input logic [15:0] a);
      return a inside {HLEF_ADDR_L2_STATUS, HLEF_ADDR_L2_ENABLE,
                       HLEF_ADDR_L3_STATUS, HLEF_ADDR_L3_ENABLE};
   endfunction
   rd_answer_a: assert property (rd_take |=> s_axi_rvalid)
      else $error("read answer late");
   rd_okay_a: assert property (rd_take ##0 mapped(s_axi_araddr) |=>
      s_axi_rresp == HLEF_RESP_OKAY && s_axi_rdata[31:8] == 24'h0)
      else $error("register read not okay");
   rd_error_a: assert property (rd_take ##0 !mapped(s_axi_araddr) |=>
      s_axi_rresp == HLEF_RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
   rd_single_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("second read taken");
   wr_answer_a: assert property (wr_take |-> ##[2:3] s_axi_bvalid)
      else $error("write answer late");
   wr_error_a: assert property (wr_take ##0 !mapped(s_axi_awaddr) |->
      ##[2:3] (s_axi_bvalid && s_axi_bresp == HLEF_RESP_SLVERR))
      else $error("unmapped write not refused");
   wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
endmodule // hlef_properties
bind hlef_top hlef_properties u_props (.*);
`default_nettype wire
